// ---- src/adc_seq_defs.svh ----
// Functional notes
// - Mode bit 0 converts one channel once; 1 scans channels repeatedly.
// - Conversion time select 0 gives 134 states maximum, 1 gives 70.
// - Channel field picks one input, or a group and highest scanned channel.
// - Trigger enable lets a pin edge start conversion; edge polarity is selectable.
// - Trigger control bits 6 to 1 ignore writes and read as 1.
// - Each conversion is successive approximation giving a 10-bit result.
// - Single mode stores result into the channel's result register.
// - Single mode end sets end flag and interrupt when enabled.
// - Single mode start reads 1 during conversion, cleared at end, then idle.
// - Scan start begins at group's first input; at most four channels.
// - Scan stores each channel result into its own result register in order.
// - Scan end of last channel sets flag, interrupt, restarts at first channel.
// - Scan never clears start by hardware; stops when software clears it.
// - A start delay precedes sampling, varying with write timing.
// - First delay 6-9 or 4-5 states; total 131-134 or 69-70 states.
// - Sampling lasts 31 or 15 states, within the conversion time.
// - Later scan conversions take fixed 128 or 66 states.
// - Enabled trigger edge sets start; conversion then acts as software start.
// - End flag clears by writing 0 after reading it as 1.
// - Result sits in bits 15 to 6, low bits read 0, reset zero.
// - Upper byte read latches lower byte for a later lower byte read.
// - Inputs 0/4, 1/5, 2/6, 3/7 share result registers a, b, c, d.
`ifndef ADC_SEQ_DEFS_SVH
`define ADC_SEQ_DEFS_SVH

// =====================================================================
// Register offsets
`define CSR_OFFSET 12'h000
`define TRIG_OFFSET 12'h004
`define EDGE_OFFSET 12'h008
`define RESULT_BASE 12'h010
`define RESULT_UPPER_BASE 12'h020
`define RESULT_LOWER_OFFSET 12'h030

// =====================================================================
// Field positions
`define CSR_FLAG_BIT 7
`define CSR_IRQ_EN_BIT 6
`define CSR_START_BIT 5
`define CSR_SCAN_BIT 4
`define CSR_CKS_BIT 3
`define CSR_CH_TOP_BIT 2
`define TRIG_EN_BIT 7
`define TRIG_RSVD_BIT 0
`define TRIG_ONES 6'h3f
`define EDGE_SEL_BIT 5
`define RESULT_SHIFT 6

// =====================================================================
// Reset values
`define CSR_RESET 8'h00
`define TRIG_RESET 1'b0
`define EDGE_RESET 1'b0
`define RESULT_RESET 10'h000

// =====================================================================
// Timing counts in states
`define DELAY_MIN_SLOW 6
`define DELAY_MAX_SLOW 9
`define DELAY_MIN_FAST 4
`define DELAY_MAX_FAST 5
`define SAMPLE_SLOW 31
`define SAMPLE_FAST 15
`define CONV_MAX_SLOW 134
`define CONV_MAX_FAST 70
`define SCAN_NEXT_SLOW 128
`define SCAN_NEXT_FAST 66
`define RESULT_WIDTH 10
`define PIPE_FIRST 3
`define PIPE_NEXT 2
`define ENGINE_SLOW (`CONV_MAX_SLOW - `DELAY_MAX_SLOW - `PIPE_FIRST)
`define ENGINE_FAST (`CONV_MAX_FAST - `DELAY_MAX_FAST - `PIPE_FIRST)
`define BIT_SLOW ((`ENGINE_SLOW - `SAMPLE_SLOW) / `RESULT_WIDTH)
`define BIT_FAST ((`ENGINE_FAST - `SAMPLE_FAST) / `RESULT_WIDTH)
`define TAIL_SLOW (`ENGINE_SLOW - `SAMPLE_SLOW - `RESULT_WIDTH * `BIT_SLOW)
`define TAIL_FAST (`ENGINE_FAST - `SAMPLE_FAST - `RESULT_WIDTH * `BIT_FAST)
`define NEXT_DELAY_SLOW (`SCAN_NEXT_SLOW - `ENGINE_SLOW - `PIPE_NEXT)
`define NEXT_DELAY_FAST (`SCAN_NEXT_FAST - `ENGINE_FAST - `PIPE_NEXT)

`endif

// ---- src/adc_seq_pkg.sv ----
package adc_seq_pkg;

    // =====================================================================
    // Sequencer states
    typedef enum logic [2:0] {
        seq_idle = 3'b001,
        seq_delay = 3'b010,
        seq_convert = 3'b100
    } seq_state_t;

    // =====================================================================
    // Approximation engine states
    typedef enum logic [3:0] {
        eng_idle = 4'b0001,
        eng_sample = 4'b0010,
        eng_bits = 4'b0100,
        eng_tail = 4'b1000
    } eng_state_t;

endpackage

// ---- src/adc_sequencer_control.sv ----
`timescale 1ns/10ps
`include "adc_seq_defs.svh"

module adc_sequencer_control #(
    parameter int RESULT_BITS = `RESULT_WIDTH,
    parameter int NUM_CHANNELS = 8
) (
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic external_trigger_pin,
    input wire logic comparator_in,
    output logic [2:0] analog_channel,
    output logic sample_hold,
    output logic [RESULT_BITS-1:0] dac_code,
    output logic conversion_end_interrupt
);

    generate
        if (NUM_CHANNELS != 8 || RESULT_BITS != `RESULT_WIDTH) begin : g_bad_cfg
            $error("adc_sequencer_control: only eight channels of ten bits supported");
        end
    endgenerate

    // =====================================================================
    // Helpers
    function automatic logic [15:0] fmt_result(input logic [RESULT_BITS-1:0] r);
        fmt_result = 16'(r) << `RESULT_SHIFT;
    endfunction

    function automatic logic [7:0] clip8(input int v);
        clip8 = 8'(v);
    endfunction

    // =====================================================================
    // Register state
    logic end_flag_ff;
    logic end_irq_enable_ff;
    logic start_bit_ff;
    logic scan_mode_ff;
    logic conversion_time_select_ff;
    logic [2:0] channel_select_ff;
    logic trigger_enable_ff;
    logic trig_rsvd_ff;
    logic trigger_edge_select_ff;
    logic flag_armed_ff;
    logic [RESULT_BITS-1:0] result_ff [4];
    logic [7:0] low_latch_ff;
    logic [1:0] phase_ff;

    logic [7:0] nxt_csr_bits;
    logic nxt_start_bit;
    logic nxt_end_flag;

    // =====================================================================
    // Sequencer state
    adc_seq_pkg::seq_state_t seq_ff;
    logic [7:0] delay_ff;
    logic [2:0] cur_chan_ff;
    logic eng_start_ff;

    // =====================================================================
    // Trigger pin synchroniser and edge detect
    logic trig_meta_ff;
    logic trig_sync_ff;
    logic trig_prev_ff;
    logic comp_meta_ff;
    logic comp_sync_ff;

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            trig_meta_ff <= 1'b1;
            trig_sync_ff <= 1'b1;
            trig_prev_ff <= 1'b1;
            comp_meta_ff <= 1'b0;
            comp_sync_ff <= 1'b0;
        end else begin
            trig_meta_ff <= external_trigger_pin;
            trig_sync_ff <= trig_meta_ff;
            trig_prev_ff <= trig_sync_ff;
            comp_meta_ff <= comparator_in;
            comp_sync_ff <= comp_meta_ff;
        end
    end

    wire trig_fall = trig_prev_ff & ~trig_sync_ff;
    wire trig_rise = ~trig_prev_ff & trig_sync_ff;
    wire trig_edge = trigger_edge_select_ff ? trig_rise : trig_fall;
    wire trig_start = trigger_enable_ff & trig_edge;

    // =====================================================================
    // Bus decode
    wire setup_phase = psel & ~penable & ~pready;
    wire access = psel & penable & pready;
    wire wr_access = access & pwrite;
    wire rd_access = access & ~pwrite;
    wire sel_csr = (paddr == `CSR_OFFSET);
    wire sel_trig = (paddr == `TRIG_OFFSET);
    wire sel_edge = (paddr == `EDGE_OFFSET);
    wire sel_word = (paddr[11:4] == `RESULT_BASE >> 4) & (paddr[1:0] == 2'b00);
    wire sel_upper = (paddr[11:4] == `RESULT_UPPER_BASE >> 4) & (paddr[1:0] == 2'b00);
    wire sel_lower = (paddr == `RESULT_LOWER_OFFSET);
    wire mapped = sel_csr | sel_trig | sel_edge | sel_word | sel_upper | sel_lower;
    wire [1:0] res_idx = paddr[3:2];
    wire [15:0] res_word = fmt_result(result_ff[res_idx]);
    wire csr_wr = wr_access & sel_csr;

    wire [7:0] csr_read = {end_flag_ff, end_irq_enable_ff, start_bit_ff, scan_mode_ff,
                           conversion_time_select_ff, channel_select_ff};
    wire [7:0] trig_read = {trigger_enable_ff, `TRIG_ONES, trig_rsvd_ff};
    wire [7:0] edge_read = 8'(trigger_edge_select_ff) << `EDGE_SEL_BIT;

    wire [31:0] read_mux = sel_csr ? {24'h000000, csr_read} :
                           sel_trig ? {24'h000000, trig_read} :
                           sel_edge ? {24'h000000, edge_read} :
                           sel_word ? {16'h0000, res_word} :
                           sel_upper ? {24'h000000, res_word[15:8]} :
                           sel_lower ? {24'h000000, low_latch_ff} : 32'h00000000;

    // =====================================================================
    // Bus answer: one wait-free access after each setup
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
        end else begin
            pready <= setup_phase;
            pslverr <= setup_phase & ~mapped;
            if (setup_phase) begin
                prdata <= pwrite ? 32'h00000000 : read_mux;
            end
        end
    end

    // =====================================================================
    // Conversion timing selection
    wire [7:0] first_delay = conversion_time_select_ff ?
        clip8(`DELAY_MIN_FAST) + {7'h00, phase_ff[0]} :
        clip8(`DELAY_MIN_SLOW) + {6'h00, phase_ff};
    wire [7:0] next_delay = conversion_time_select_ff ?
        clip8(`NEXT_DELAY_FAST) : clip8(`NEXT_DELAY_SLOW);
    wire [7:0] sample_len = conversion_time_select_ff ?
        clip8(`SAMPLE_FAST) : clip8(`SAMPLE_SLOW);
    wire [7:0] bit_len = conversion_time_select_ff ?
        clip8(`BIT_FAST) : clip8(`BIT_SLOW);
    wire [7:0] tail_len = conversion_time_select_ff ?
        clip8(`TAIL_FAST) : clip8(`TAIL_SLOW);

    // =====================================================================
    // Channel selection
    wire [2:0] group_first = {channel_select_ff[2], 2'b00};
    wire [2:0] group_last = channel_select_ff;
    wire [2:0] first_chan = scan_mode_ff ? group_first : channel_select_ff;
    wire scan_wrap = (cur_chan_ff == group_last);
    wire [2:0] following_chan = scan_wrap ? group_first : cur_chan_ff + 3'h1;

    // =====================================================================
    // Engine hookup
    wire eng_done;
    wire [RESULT_BITS-1:0] eng_result;
    wire abort = (seq_ff != adc_seq_pkg::seq_idle) & ~start_bit_ff;

    sar_engine #(
        .RESULT_BITS(RESULT_BITS)
    ) u_engine (
        .ref_clk(ref_clk),
        .reset_n(reset_n),
        .start(eng_start_ff),
        .abort(abort),
        .sample_len(sample_len),
        .bit_len(bit_len),
        .tail_len(tail_len),
        .comp_high(comp_sync_ff),
        .sample_on(sample_hold),
        .dac_code(dac_code),
        .result(eng_result),
        .done(eng_done)
    );

    wire conv_end = eng_done & (seq_ff == adc_seq_pkg::seq_convert) & start_bit_ff;
    wire single_end = conv_end & ~scan_mode_ff;
    wire scan_round_end = conv_end & scan_mode_ff & scan_wrap;
    wire set_flag = single_end | scan_round_end;

    // =====================================================================
    // Sequencer
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            seq_ff <= adc_seq_pkg::seq_idle;
            delay_ff <= 8'h00;
            cur_chan_ff <= 3'h0;
            eng_start_ff <= 1'b0;
        end else begin
            eng_start_ff <= 1'b0;
            unique case (seq_ff)
                adc_seq_pkg::seq_idle: begin
                    if (start_bit_ff) begin
                        seq_ff <= adc_seq_pkg::seq_delay;
                        delay_ff <= first_delay - 8'h01;
                        cur_chan_ff <= first_chan;
                    end
                end
                adc_seq_pkg::seq_delay: begin
                    delay_ff <= delay_ff - 8'h01;
                    if (abort) begin
                        seq_ff <= adc_seq_pkg::seq_idle;
                    end else if (delay_ff == 8'h00) begin
                        seq_ff <= adc_seq_pkg::seq_convert;
                        eng_start_ff <= 1'b1;
                    end
                end
                adc_seq_pkg::seq_convert: begin
                    if (abort) begin
                        seq_ff <= adc_seq_pkg::seq_idle;
                    end else if (single_end) begin
                        seq_ff <= adc_seq_pkg::seq_idle;
                    end else if (conv_end) begin
                        seq_ff <= adc_seq_pkg::seq_delay;
                        delay_ff <= next_delay - 8'h01;
                        cur_chan_ff <= following_chan;
                    end
                end
                default: begin
                    seq_ff <= adc_seq_pkg::seq_idle;
                end
            endcase
        end
    end

    // =====================================================================
    // Result storage
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            for (int i = 0; i < 4; i++) begin
                result_ff[i] <= `RESULT_RESET;
            end
            low_latch_ff <= 8'h00;
        end else begin
            if (conv_end) begin
                result_ff[cur_chan_ff[1:0]] <= eng_result;
            end
            if (rd_access & sel_upper) begin
                low_latch_ff <= res_word[7:0];
            end
        end
    end

    // =====================================================================
    // Control and status next values
    always_comb begin
        nxt_csr_bits = csr_wr ? pwdata[7:0] : csr_read;
        nxt_start_bit = nxt_csr_bits[`CSR_START_BIT];
        if (trig_start) begin
            nxt_start_bit = 1'b1;
        end
        if (single_end) begin
            nxt_start_bit = 1'b0;
        end
        nxt_end_flag = end_flag_ff;
        if (csr_wr & ~pwdata[`CSR_FLAG_BIT] & flag_armed_ff) begin
            nxt_end_flag = 1'b0;
        end
        if (set_flag) begin
            nxt_end_flag = 1'b1;
        end
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            end_flag_ff <= 1'(`CSR_RESET >> `CSR_FLAG_BIT);
            end_irq_enable_ff <= 1'b0;
            start_bit_ff <= 1'b0;
            scan_mode_ff <= 1'b0;
            conversion_time_select_ff <= 1'b0;
            channel_select_ff <= 3'h0;
            flag_armed_ff <= 1'b0;
            phase_ff <= 2'h0;
        end else begin
            phase_ff <= phase_ff + 2'h1;
            end_flag_ff <= nxt_end_flag;
            start_bit_ff <= nxt_start_bit;
            end_irq_enable_ff <= nxt_csr_bits[`CSR_IRQ_EN_BIT];
            scan_mode_ff <= nxt_csr_bits[`CSR_SCAN_BIT];
            conversion_time_select_ff <= nxt_csr_bits[`CSR_CKS_BIT];
            channel_select_ff <= nxt_csr_bits[`CSR_CH_TOP_BIT:0];
            if (csr_wr) begin
                flag_armed_ff <= 1'b0;
            end else if (rd_access & sel_csr & prdata[`CSR_FLAG_BIT]) begin
                flag_armed_ff <= 1'b1;
            end
        end
    end

    // =====================================================================
    // Trigger control, edge select and outputs
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            trigger_enable_ff <= `TRIG_RESET;
            trig_rsvd_ff <= `TRIG_RESET;
            trigger_edge_select_ff <= `EDGE_RESET;
            analog_channel <= 3'h0;
            conversion_end_interrupt <= 1'b0;
        end else begin
            if (wr_access & sel_trig) begin
                trigger_enable_ff <= pwdata[`TRIG_EN_BIT];
                trig_rsvd_ff <= pwdata[`TRIG_RSVD_BIT];
            end
            if (wr_access & sel_edge) begin
                trigger_edge_select_ff <= pwdata[`EDGE_SEL_BIT];
            end
            analog_channel <= cur_chan_ff;
            conversion_end_interrupt <= end_flag_ff & end_irq_enable_ff;
        end
    end

endmodule

// ---- src/sar_engine.sv ----
`timescale 1ns/10ps
`include "adc_seq_defs.svh"

module sar_engine #(
    parameter int RESULT_BITS = `RESULT_WIDTH
) (
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic start,
    input wire logic abort,
    input wire logic [7:0] sample_len,
    input wire logic [7:0] bit_len,
    input wire logic [7:0] tail_len,
    input wire logic comp_high,
    output logic sample_on,
    output logic [RESULT_BITS-1:0] dac_code,
    output logic [RESULT_BITS-1:0] result,
    output logic done
);

    generate
        if (RESULT_BITS < 2 || RESULT_BITS > 15) begin : g_bad_width
            $error("sar_engine: unsupported result width");
        end
    endgenerate

    adc_seq_pkg::eng_state_t state_ff;
    logic [7:0] cnt_ff;
    logic [3:0] idx_ff;

    // =====================================================================
    // Trial decode
    wire cnt_zero = (cnt_ff == 8'h00);
    wire [RESULT_BITS-1:0] cur_bit = RESULT_BITS'(1) << idx_ff;
    wire [RESULT_BITS-1:0] kept = comp_high ? dac_code : (dac_code & ~cur_bit);
    wire [RESULT_BITS-1:0] next_bit = cur_bit >> 1;
    wire last_bit = (idx_ff == 4'h0);

    // =====================================================================
    // Sample, then one trial per bit from the top down
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            state_ff <= adc_seq_pkg::eng_idle;
            cnt_ff <= 8'h00;
            idx_ff <= 4'h0;
            sample_on <= 1'b0;
            dac_code <= '0;
            result <= '0;
            done <= 1'b0;
        end else begin
            done <= 1'b0;
            if (abort) begin
                state_ff <= adc_seq_pkg::eng_idle;
                sample_on <= 1'b0;
            end else begin
                unique case (state_ff)
                    adc_seq_pkg::eng_idle: begin
                        if (start) begin
                            state_ff <= adc_seq_pkg::eng_sample;
                            cnt_ff <= sample_len - 8'h01;
                            sample_on <= 1'b1;
                            dac_code <= '0;
                        end
                    end
                    adc_seq_pkg::eng_sample: begin
                        cnt_ff <= cnt_ff - 8'h01;
                        if (cnt_zero) begin
                            state_ff <= adc_seq_pkg::eng_bits;
                            sample_on <= 1'b0;
                            idx_ff <= 4'(RESULT_BITS - 1);
                            dac_code <= RESULT_BITS'(1) << (RESULT_BITS - 1);
                            cnt_ff <= bit_len - 8'h01;
                        end
                    end
                    adc_seq_pkg::eng_bits: begin
                        cnt_ff <= cnt_ff - 8'h01;
                        if (cnt_zero) begin
                            cnt_ff <= bit_len - 8'h01;
                            idx_ff <= idx_ff - 4'h1;
                            if (last_bit) begin
                                dac_code <= kept;
                                result <= kept;
                                cnt_ff <= tail_len - 8'h01;
                                if (tail_len == 8'h00) begin
                                    state_ff <= adc_seq_pkg::eng_idle;
                                    done <= 1'b1;
                                end else begin
                                    state_ff <= adc_seq_pkg::eng_tail;
                                end
                            end else begin
                                dac_code <= kept | next_bit;
                            end
                        end
                    end
                    adc_seq_pkg::eng_tail: begin
                        cnt_ff <= cnt_ff - 8'h01;
                        if (cnt_zero) begin
                            state_ff <= adc_seq_pkg::eng_idle;
                            done <= 1'b1;
                        end
                    end
                    default: begin
                        state_ff <= adc_seq_pkg::eng_idle;
                    end
                endcase
            end
        end
    end

endmodule

// ---- test/adc_analog_model.sv ----
`timescale 1ns/10ps
// ==========
// Analog inputs held steady and one comparator
module adc_analog_model (
    input wire logic [2:0] analog_channel,
    input wire logic [9:0] dac_code,
    input wire logic [79:0] levels,
    output logic comparator_in
);
    assign comparator_in = levels[analog_channel*10 +: 10] >= dac_code;
endmodule

// ---- test/adc_sequencer_control_monitor.sv ----
`timescale 1ns/10ps
// ==========
// Bus and conversion checks
module adc_sequencer_control_monitor #(
    parameter int RESULT_BITS = 10
) (
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic [11:0] paddr,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [2:0] analog_channel,
    input wire logic sample_hold,
    input wire logic [RESULT_BITS-1:0] dac_code
);
    logic [7:0] samp_ff;
    logic [7:0] gap_ff;
    wire mapped = paddr[1:0] == 2'h0 && paddr <= 12'h030 && paddr != 12'h00c;
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            samp_ff <= 8'h00;
            gap_ff <= 8'hff;
        end else begin
            samp_ff <= sample_hold ? samp_ff + 8'h01 : 8'h00;
            gap_ff <= (sample_hold && samp_ff == 8'h00) ? 8'h01 : gap_ff + {7'h0, gap_ff != 8'hff};
        end
    end
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!reset_n);
    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_samp_end;
        $fell(sample_hold);
    endsequence
    AST_PREADY_AFTER_SETUP: assert property (s_setup |=> pready) else $error("pready missing");
    AST_PREADY_ONE_CYCLE: assert property (pready |=> !pready) else $error("pready too long");
    AST_SLVERR_WITH_READY: assert property (pslverr |-> pready) else $error("pslverr alone");
    AST_UNMAPPED_ERR: assert property ((s_setup and !mapped) |=> pslverr) else $error("unmapped ok");
    AST_MAPPED_OK: assert property ((s_setup and mapped) |=> !pslverr) else $error("mapped error");
    AST_SAMPLE_LEN: assert property (s_samp_end |-> samp_ff == 8'd31 || samp_ff == 8'd15)
        else $error("sampling length wrong");
    AST_CHANNEL_HELD: assert property (sample_hold ##1 sample_hold |-> $stable(analog_channel))
        else $error("channel moved in sampling");
    AST_MSB_TRIAL: assert property (s_samp_end |-> ##[0:12] dac_code == {1'b1, {(RESULT_BITS-1){1'b0}}})
        else $error("no msb trial");
    AST_SCAN_SPACING: assert property ($rose(sample_hold) |-> gap_ff >= 8'd66)
        else $error("conversions too close");
endmodule
bind adc_sequencer_control adc_sequencer_control_monitor #(.RESULT_BITS(RESULT_BITS)) u_mon (.ref_clk(ref_clk),
    .reset_n(reset_n), .psel(psel), .penable(penable), .paddr(paddr), .pready(pready), .pslverr(pslverr),
    .analog_channel(analog_channel), .sample_hold(sample_hold), .dac_code(dac_code));

// ---- test/adc_sequencer_control_tb.sv ----
`timescale 1ns/10ps
module adc_sequencer_control_tb;
    logic ref_clk = 0, reset_n = 0, psel = 0, penable = 0, pwrite = 0, trig = 1, k = 0;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, q;
    logic pready, pslverr, err, cmp, samp, irq;
    logic [2:0] chan;
    logic [9:0] dac;
    logic [79:0] lv = 0;
    int n_fail = 0, checks_done = 0, seed = 97724, cyc = 0, nr = 0, nw = 0, n0 = 0;
    always #5 ref_clk = ~ref_clk;
    always @(posedge samp) nr++;
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 60000) begin
            n_fail++;
            give_verdict;
        end
    end
    adc_sequencer_control dut (.ref_clk(ref_clk), .reset_n(reset_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .external_trigger_pin(trig), .comparator_in(cmp), .analog_channel(chan), .sample_hold(samp),
        .dac_code(dac), .conversion_end_interrupt(irq));
    adc_analog_model u_far (.analog_channel(chan), .dac_code(dac), .levels(lv), .comparator_in(cmp));
    // ==========
    // Bus cycles, compares and expectations
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1;
        do begin
            @(posedge ref_clk);
        end while (pready !== 1'b1);
        q = prdata;
        err = pslverr;
        psel <= 0;
        penable <= 0;
        @(posedge ref_clk);
    endtask
    task chk(input string s, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            $display("MISMATCH %s expected %h seen %h", s, e, g);
            n_fail++;
        end
    endtask
    task rd(input logic [11:0] a, input logic [31:0] e, input string s);
        apb(0, a, 32'h0);
        chk(s, e, q);
    endtask
    task wait_irq;
        nw = 0;
        while (irq !== 1'b1 && nw < 400) begin
            @(posedge ref_clk);
            nw++;
        end
    endtask
    function logic [31:0] res(input int c);
        return {16'h0, lv[c*10 +: 10], 6'h00};
    endfunction
    task give_verdict;
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    // ==========
    // Main sequence
    initial begin
        for (int i = 0; i < 8; i++) lv[i*10 +: 10] = 10'($random(seed));
        repeat (5) @(posedge ref_clk);
        reset_n <= 1;
        @(posedge ref_clk);
        rd(12'h000, 32'h0, "csr");
        rd(12'h004, 32'h7e, "trig");
        rd(12'h014, 32'h0, "result");
        apb(1, 12'h004, 32'h80);
        rd(12'h004, 32'hfe, "trig");
        apb(1, 12'h004, 32'h0);
        apb(0, 12'h040, 32'h0);
        chk("slverr", 32'h1, {31'h0, err});
        $display("registers done");
        for (int c = 0; c < 8; c++) begin
            k = 1'($random(seed));
            apb(1, 12'h000, 32'h60 | (k << 3) | c);
            wait_irq;
            chk("time", 32'h1, {31'h0, k ? (nw >= 70 && nw <= 71) : (nw >= 132 && nw <= 135)});
            apb(1, 12'h000, 32'h40 | (k << 3) | c);
            rd(12'h000, 32'hc0 | (k << 3) | c, "csr");
            apb(1, 12'h000, 32'h40 | (k << 3) | c);
            rd(12'h000, 32'h40 | (k << 3) | c, "csr");
            rd(12'(16 + 4 * (c % 4)), res(c), "result");
            rd(12'(32 + 4 * (c % 4)), {24'h0, lv[c*10+2 +: 8]}, "upper");
            rd(12'h030, {24'h0, lv[c*10 +: 2], 6'h00}, "lower");
        end
        $display("single done");
        apb(1, 12'h000, 32'h7e);
        wait_irq;
        rd(12'h000, 32'hfe, "csr");
        for (int c = 4; c < 8; c++) rd(12'(16 + 4 * (c % 4)), res(c == 7 ? 7 : c), "result");
        @(negedge samp);
        repeat (20) @(posedge ref_clk);
        apb(1, 12'h000, 32'h5e);
        n0 = nr;
        repeat (300) @(posedge ref_clk);
        chk("stopped", n0, nr);
        $display("scan done");
        apb(1, 12'h004, 32'h80);
        for (int p = 0; p < 2; p++) begin
            apb(1, 12'h008, p << 5);
            apb(1, 12'h000, 32'h42);
            n0 = nr;
            trig <= 0;
            repeat (4) @(posedge ref_clk);
            trig <= 1;
            repeat (30) @(posedge ref_clk);
            trig <= 0;
            repeat (4) @(posedge ref_clk);
            trig <= 1;
            wait_irq;
            rd(12'h000, 32'hc2, "csr");
            apb(1, 12'h000, 32'h42);
            chk("one run", n0 + 1, nr);
        end
        $display("trigger done");
        give_verdict;
    end
endmodule
